// *** rtl/dsw_input_deserializer.sv ***
// How it works
// - Strobe-capture model: strobe stage adds exactly one word clock of latency.
// - Link-capture model: serial input to parallel output takes two word clocks with slip enabled, one with slip disabled.
// - The extra link-model word clock comes from the input word register.
// - Double rate captures a bit on every serial rising and falling edge.
// - Bits are captured only while the first capture enable is high.
// - The reset pin clears serial and word state at once, without a clock.
// - Reset release waits for a word edge, then for a serial edge.
// - Repeated slips present every rotation of a repeating training pattern.
// - Every slip is taken on a word clock edge.
// - Single rate: each slip rotates the word left by one bit.
// - Double rate: slips alternate right one, left three, right first.
// - Eight slips on an eight-bit word restore the first alignment.
// - With slip disabled the slip request changes nothing.
// - Realigned word is sampled one word clock after the slip is taken.
// - While the rotation is zero words pass through unrotated.
// - With slip disabled the slip stage is skipped entirely.
`timescale 1ns/1ns
module dsw_input_deserializer
  import dsw_pkg::*;
#(
  parameter int WORD_W = DSW_WORD_W
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic serial_clk,
  input wire logic word_clock,
  input wire logic strobe_domain_clock,
  input wire logic serial_data,
  input wire logic first_capture_enable,
  input wire logic second_capture_enable,
  input wire logic slip_request,
  input wire logic deser_reset,
  output logic [WORD_W-1:0] parallel_word_out
);

  localparam int RW = (WORD_W > 2) ? $clog2(WORD_W) : 1;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [WORD_W-1:0] rotl(input logic [WORD_W-1:0] w, input logic [RW-1:0] n);
    logic [WORD_W-1:0] r;
    r = w;
    for (int i = 0; i < WORD_W; i++) begin
      if (i < int'(n)) begin
        r = {r[WORD_W-2:0], r[WORD_W-1]};
      end
    end
    return r;
  endfunction : rotl

  function automatic logic [RW-1:0] rot_add(input logic [RW-1:0] rot, input int amt);
    int s;
    s = (int'(rot) + amt) % WORD_W;
    return RW'(s);
  endfunction : rot_add

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  dsw_pins_t pins_raw;
  dsw_pins_t pins_lvl;
  dsw_pins_t pins_rise;
  dsw_pins_t pins_fall;
  logic [DSW_PIN_W-1:0] lvl_w;
  logic [DSW_PIN_W-1:0] rise_w;
  logic [DSW_PIN_W-1:0] fall_w;

  assign pins_raw = {deser_reset, slip_request, second_capture_enable, first_capture_enable,
                     serial_data, strobe_domain_clock, word_clock, serial_clk};

  dsw_pin_sync #(
    .N(DSW_PIN_W)
  ) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .pins_in(pins_raw),
    .lvl(lvl_w),
    .rise(rise_w),
    .fall(fall_w)
  );

  assign pins_lvl = lvl_w;
  assign pins_rise = rise_w;
  assign pins_fall = fall_w;

  // ---------------------------------------------------------------
  // Reset
  // ---------------------------------------------------------------
  // Pin assertion clears state at once; release is retimed below
  logic arst_n;
  logic word_rst;
  logic serial_rst;

  assign arst_n = hresetn & ~deser_reset;

  dsw_rst_seq u_rst (
    .hclk(hclk),
    .arst_n(arst_n),
    .rst_req(pins_lvl.rst),
    .word_edge(pins_rise.word_clk),
    .serial_edge(pins_rise.serial_clk),
    .word_rst(word_rst),
    .serial_rst(serial_rst)
  );

  // ---------------------------------------------------------------
  // Control register and mode decode
  // ---------------------------------------------------------------
  logic [DSW_CTRL_W-1:0] ctrl_r;
  logic ddr;
  logic link_mode;
  logic slip_on;

  assign ddr = ctrl_r[DSW_CTRL_DDR];
  assign link_mode = ctrl_r[DSW_CTRL_LINK];
  // Slip lives only in the link model
  assign slip_on = ctrl_r[DSW_CTRL_SLIP_EN] & link_mode;

  // ---------------------------------------------------------------
  // Serial capture
  // ---------------------------------------------------------------
  logic ser_cap;
  logic [WORD_W-1:0] shift_r;

  assign ser_cap = !serial_rst && pins_lvl.ce1 &&
                   (pins_rise.serial_clk || (ddr && pins_fall.serial_clk));

  always_ff @(posedge hclk or negedge arst_n) begin
    if (!arst_n) begin
      shift_r <= '0;
    end else if (serial_rst) begin
      shift_r <= '0;
    end else if (ser_cap) begin
      shift_r <= {shift_r[WORD_W-2:0], pins_lvl.data};
    end
  end

  // ---------------------------------------------------------------
  // Word stages
  // ---------------------------------------------------------------
  logic word_edge;
  logic strobe_edge;
  logic [WORD_W-1:0] in_word_r;
  logic [WORD_W-1:0] strobe_word_r;

  assign word_edge = pins_rise.word_clk && !word_rst;
  assign strobe_edge = pins_rise.strobe_clk && !word_rst;

  always_ff @(posedge hclk or negedge arst_n) begin
    if (!arst_n) begin
      in_word_r <= '0;
    end else if (word_rst) begin
      in_word_r <= '0;
    end else if (word_edge && pins_lvl.ce2) begin
      in_word_r <= shift_r;
    end
  end

  always_ff @(posedge hclk or negedge arst_n) begin
    if (!arst_n) begin
      strobe_word_r <= '0;
    end else if (word_rst) begin
      strobe_word_r <= '0;
    end else if (strobe_edge) begin
      strobe_word_r <= shift_r;
    end
  end

  // ---------------------------------------------------------------
  // Word slip control
  // ---------------------------------------------------------------
  // Rotation kept as a left offset so the pattern wraps cleanly
  logic slip_take;
  logic [RW-1:0] rot_r;
  logic phase_r;
  logic [15:0] slip_cnt_r;

  assign slip_take = word_edge && pins_lvl.slip && slip_on;

  always_ff @(posedge hclk or negedge arst_n) begin
    if (!arst_n) begin
      rot_r <= '0;
      phase_r <= 1'b0;
    end else if (word_rst) begin
      rot_r <= '0;
      phase_r <= 1'b0;
    end else if (slip_take) begin
      if (!ddr) begin
        rot_r <= rot_add(rot_r, 1);
      end else if (!phase_r) begin
        rot_r <= rot_add(rot_r, WORD_W - 1);
        phase_r <= 1'b1;
      end else begin
        rot_r <= rot_add(rot_r, 3);
        phase_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge arst_n) begin
    if (!arst_n) begin
      slip_cnt_r <= '0;
    end else if (slip_take) begin
      slip_cnt_r <= slip_cnt_r + 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // Output stage
  // ---------------------------------------------------------------
  // Slip register doubles as output register, hence two word clocks
  always_ff @(posedge hclk or negedge arst_n) begin
    if (!arst_n) begin
      parallel_word_out <= '0;
    end else if (word_rst) begin
      parallel_word_out <= '0;
    end else if (word_edge) begin
      if (!link_mode) begin
        parallel_word_out <= strobe_word_r;
      end else if (slip_on) begin
        parallel_word_out <= rotl(in_word_r, rot_r);
      end else begin
        parallel_word_out <= shift_r;
      end
    end
  end

  // ---------------------------------------------------------------
  // AHB-Lite slave
  // ---------------------------------------------------------------
  logic ahb_go;
  logic dp_wr_r;
  logic [7:0] dp_addr_r;

  assign ahb_go = hsel && htrans[1] && hready;

  function automatic logic [31:0] reg_read(input logic [7:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    if (a == DSW_OFF_CTRL) begin
      d[DSW_CTRL_W-1:0] = ctrl_r;
    end else if (a == DSW_OFF_WORD) begin
      d[WORD_W-1:0] = parallel_word_out;
    end else if (a == DSW_OFF_STATUS) begin
      d[DSW_STAT_ROT +: RW] = rot_r;
      d[DSW_STAT_PHASE] = phase_r;
      d[DSW_STAT_WORD_RST] = word_rst;
      d[DSW_STAT_SER_RST] = serial_rst;
    end else if (a == DSW_OFF_SLIPS) begin
      d[15:0] = slip_cnt_r;
    end
    return d;
  endfunction : reg_read

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_r <= 1'b0;
      dp_addr_r <= 8'h00;
    end else begin
      dp_wr_r <= ahb_go && hwrite;
      dp_addr_r <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= DSW_CTRL_RST;
    end else if (dp_wr_r && dp_addr_r == DSW_OFF_CTRL) begin
      ctrl_r <= hwdata[DSW_CTRL_W-1:0];
    end
  end

  // Zero wait states: read data is set up during the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (ahb_go && !hwrite) begin
      hrdata <= reg_read(haddr[7:0]);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_sdr_rise_capture: assert property (
    @(posedge hclk) disable iff (!arst_n)
    (!ddr && pins_rise.serial_clk && pins_lvl.ce1 && !serial_rst) |=> shift_r[0] == $past(pins_lvl.data)
  ) else $error("rising edge bit not captured");

  a_ddr_fall_capture: assert property (
    @(posedge hclk) disable iff (!arst_n)
    (ddr && pins_fall.serial_clk && pins_lvl.ce1 && !serial_rst) |=> shift_r[0] == $past(pins_lvl.data)
  ) else $error("falling edge bit not captured");

  a_ce_low_hold: assert property (
    @(posedge hclk) disable iff (!arst_n)
    (!pins_lvl.ce1 && !serial_rst) |=> $stable(shift_r)
  ) else $error("shift moved with enable low");

  a_sdr_slip_step: assert property (
    @(posedge hclk) disable iff (!arst_n)
    (slip_take && !ddr && !word_rst) |=> rot_r == rot_add($past(rot_r), 1)
  ) else $error("single rate slip not left one");

  a_ddr_slip_alt: assert property (
    @(posedge hclk) disable iff (!arst_n)
    (slip_take && ddr) |=> phase_r == !$past(phase_r) &&
      rot_r == rot_add($past(rot_r), $past(phase_r) ? 3 : WORD_W - 1)
  ) else $error("double rate slip order wrong");

  a_slip_off_still: assert property (
    @(posedge hclk) disable iff (!arst_n)
    (!slip_on && !word_rst) |=> $stable(rot_r) && $stable(phase_r)
  ) else $error("slip acted while disabled");

  a_link_rot_word: assert property (
    @(posedge hclk) disable iff (!arst_n)
    (word_edge && slip_on) |=> parallel_word_out == rotl($past(in_word_r), $past(rot_r))
  ) else $error("slip stage output wrong");

  a_plain_pass: assert property (
    @(posedge hclk) disable iff (!arst_n)
    (word_edge && slip_on && rot_r == '0) |=> parallel_word_out == $past(in_word_r)
  ) else $error("unslipped word was rotated");

  a_strobe_one_word: assert property (
    @(posedge hclk) disable iff (!arst_n)
    (word_edge && !link_mode) |=> parallel_word_out == $past(strobe_word_r)
  ) else $error("strobe stage latency wrong");

  a_reset_order: assert property (
    @(posedge hclk) disable iff (!arst_n)
    $fell(serial_rst) |-> !word_rst && $past(pins_rise.serial_clk) && !$past(word_rst)
  ) else $error("serial reset left before word reset");

endmodule : dsw_input_deserializer

// *** rtl/dsw_pin_sync.sv ***
`timescale 1ns/1ns
module dsw_pin_sync
  import dsw_pkg::*;
#(
  parameter int N = DSW_PIN_W
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [N-1:0] pins_in,
  output logic [N-1:0] lvl,
  output logic [N-1:0] rise,
  output logic [N-1:0] fall
);

  // ---------------------------------------------------------------
  // Two stages, third for edge finding
  // ---------------------------------------------------------------
  logic [N-1:0] s1_r;
  logic [N-1:0] s2_r;
  logic [N-1:0] s3_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= pins_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  assign lvl = s2_r;
  assign rise = s2_r & ~s3_r;
  assign fall = ~s2_r & s3_r;

endmodule : dsw_pin_sync

// *** rtl/dsw_pkg.sv ***
package dsw_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int DSW_WORD_W = 4;
  localparam int DSW_CTRL_W = 3;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] DSW_OFF_CTRL = 8'h00;
  localparam logic [7:0] DSW_OFF_WORD = 8'h04;
  localparam logic [7:0] DSW_OFF_STATUS = 8'h08;
  localparam logic [7:0] DSW_OFF_SLIPS = 8'h0c;

  // ---------------------------------------------------------------
  // Control fields and reset value
  // ---------------------------------------------------------------
  localparam int DSW_CTRL_DDR = 0;
  localparam int DSW_CTRL_SLIP_EN = 1;
  localparam int DSW_CTRL_LINK = 2;
  localparam logic [DSW_CTRL_W-1:0] DSW_CTRL_RST = 3'h1;

  // ---------------------------------------------------------------
  // Status fields
  // ---------------------------------------------------------------
  localparam int DSW_STAT_ROT = 0;
  localparam int DSW_STAT_PHASE = 8;
  localparam int DSW_STAT_WORD_RST = 9;
  localparam int DSW_STAT_SER_RST = 10;

  // ---------------------------------------------------------------
  // Pin bundle and reset sequence
  // ---------------------------------------------------------------
  typedef struct packed {
    logic rst;
    logic slip;
    logic ce2;
    logic ce1;
    logic data;
    logic strobe_clk;
    logic word_clk;
    logic serial_clk;
  } dsw_pins_t;

  localparam int DSW_PIN_W = $bits(dsw_pins_t);

  typedef enum logic [1:0] {
    DSW_RS_HOLD = 2'b00,
    DSW_RS_WORD = 2'b01,
    DSW_RS_RUN = 2'b10
  } dsw_rst_state_t;

endpackage : dsw_pkg

// *** rtl/dsw_rst_seq.sv ***
`timescale 1ns/1ns
module dsw_rst_seq
  import dsw_pkg::*;
(
  input wire logic hclk,
  input wire logic arst_n,
  input wire logic rst_req,
  input wire logic word_edge,
  input wire logic serial_edge,
  output logic word_rst,
  output logic serial_rst
);

  // ---------------------------------------------------------------
  // Release: word clock first, then serial clock
  // ---------------------------------------------------------------
  dsw_rst_state_t state_r;

  always_ff @(posedge hclk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= DSW_RS_HOLD;
    end else begin
      case (state_r)
        DSW_RS_HOLD: begin
          if (word_edge && !rst_req) begin
            state_r <= DSW_RS_WORD;
          end
        end
        DSW_RS_WORD: begin
          if (rst_req) begin
            state_r <= DSW_RS_HOLD;
          end else if (serial_edge) begin
            state_r <= DSW_RS_RUN;
          end
        end
        DSW_RS_RUN: begin
          if (rst_req) begin
            state_r <= DSW_RS_HOLD;
          end
        end
        default: begin
          state_r <= DSW_RS_HOLD;
        end
      endcase
    end
  end

  assign word_rst = (state_r == DSW_RS_HOLD);
  assign serial_rst = (state_r != DSW_RS_RUN);

endmodule : dsw_rst_seq

// *** tb/dsw_link_partner.sv ***
`timescale 1ns/1ns
module dsw_link_partner (
  input wire logic ddr,
  input wire logic [7:0] pattern,
  output logic serial_clk,
  output logic word_clock,
  output logic strobe_domain_clock,
  output logic serial_data
);
  // ---------------------------------------------------------------
  // Free running link, word clock phase aligned to serial falls
  // ---------------------------------------------------------------
  int half_cnt;
  int bit_cnt;

  initial begin
    serial_clk = 1'b0;
    word_clock = 1'b0;
    strobe_domain_clock = 1'b0;
    serial_data = 1'b0;
    half_cnt = 0;
    bit_cnt = 0;
    forever begin
      #20;
      // Data moves mid phase, away from the sampling edge
      if (ddr || serial_clk) begin
        serial_data = pattern[7 - (bit_cnt % 8)];
        bit_cnt++;
      end
      #20;
      serial_clk = ~serial_clk;
      half_cnt++;
      // Eight bit word in both rates
      if (half_cnt % (ddr ? 4 : 8) == 0) begin
        word_clock = ~word_clock;
      end
    end
  end

  // Strobe lags so its load lands mid word
  always @(word_clock) begin
    strobe_domain_clock <= #100 word_clock;
  end
endmodule : dsw_link_partner

// *** tb/test_dsw_input_deserializer.sv ***
`timescale 1ns/1ns
module test_dsw_input_deserializer;
  import dsw_pkg::*;
  localparam int W = 8;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic serial_clk, word_clock, strobe_clk, serial_data, ce1, ce2, slip, drst, ddr;
  logic [7:0] pattern, w0;
  logic [W-1:0] pwo;
  int n_mismatch, cmp_count, slips;
  logic [2:0] ddr_off [8] = '{3'h7, 3'h2, 3'h1, 3'h4, 3'h3, 3'h6, 3'h5, 3'h0};

  dsw_input_deserializer #(.WORD_W(W)) i_dsw_input_deserializer (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .serial_clk(serial_clk), .word_clock(word_clock), .strobe_domain_clock(strobe_clk),
    .serial_data(serial_data), .first_capture_enable(ce1), .second_capture_enable(ce2),
    .slip_request(slip), .deser_reset(drst), .parallel_word_out(pwo)
  );
  dsw_link_partner i_dsw_link_partner (
    .ddr(ddr), .pattern(pattern), .serial_clk(serial_clk), .word_clock(word_clock),
    .strobe_domain_clock(strobe_clk), .serial_data(serial_data)
  );

  assign hready = hreadyout;
  always #5 hclk = ~hclk;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] rotl(input logic [7:0] v, input logic [2:0] k);
    return (v << k) | (v >> (4'd8 - k));
  endfunction : rotl

  function automatic logic is_rot(input logic [7:0] v);
    logic r;
    r = 1'b0;
    for (int k = 0; k < 8; k++) begin
      if (rotl(8'h93, 3'(k)) === v) r = 1'b1;
    end
    return r;
  endfunction : is_rot

  task stop_test;
    $display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test

  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      n_mismatch++;
    end
  endtask : chk

  task wait_rdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        n_mismatch++;
        stop_test();
      end
      @(posedge hclk);
    end
  endtask : wait_rdy

  // Single word transfer; entered just after a rising edge
  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    d = hrdata;
  endtask : ahb

  task wait_word;
    int n;
    logic p;
    n = 0;
    do begin
      p = word_clock;
      @(posedge hclk);
      n++;
      if (n > 200) begin
        n_mismatch++;
        stop_test();
      end
    end while (!(p === 1'b0 && word_clock === 1'b1));
  endtask : wait_word

  task slip_pulse(input logic [7:0] old_w, input logic [7:0] new_w);
    wait_word();
    repeat (4) @(posedge hclk);
    slip <= 1'b1;
    wait_word();
    repeat (8) @(posedge hclk);
    slip <= 1'b0;
    chk("word at slip edge", {24'h0, pwo}, {24'h0, old_w});
    wait_word();
    repeat (8) @(posedge hclk);
    chk("word after slip", {24'h0, pwo}, {24'h0, new_w});
    // Let the slip settle before judging the next word
    repeat (2) wait_word();
  endtask : slip_pulse

  task run_slips(input logic is_ddr, input logic [7:0] base);
    logic [2:0] off;
    logic [2:0] prev;
    prev = 3'h0;
    for (int i = 0; i < 8; i++) begin
      off = is_ddr ? ddr_off[i] : 3'(i + 1);
      slip_pulse(rotl(base, prev), rotl(base, off));
      ahb(1'b0, DSW_OFF_STATUS, 32'h0, rd);
      chk("rotation", rd & 32'h7, {29'h0, off});
      if (is_ddr) chk("slip phase", (rd >> DSW_STAT_PHASE) & 32'h1, 32'(i % 2 == 0));
      slips++;
      ahb(1'b0, DSW_OFF_SLIPS, 32'h0, rd);
      chk("slip count", rd & 32'hffff, 32'(slips));
      prev = off;
    end
    chk("realigned", {24'h0, pwo}, {24'h0, base});
  endtask : run_slips

  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    ce1 = 1'b1;
    ce2 = 1'b1;
    slip = 1'b0;
    drst = 1'b0;
    ddr = 1'b1;
    pattern = 8'h93;
    n_mismatch = 0;
    cmp_count = 0;
    slips = 0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, DSW_OFF_CTRL, 32'h0, rd);
    chk("ctrl reset", rd, {29'h0, DSW_CTRL_RST});
    ahb(1'b0, DSW_OFF_SLIPS, 32'h0, rd);
    chk("slips reset", rd, 32'h0);
    ahb(1'b1, 8'h10, 32'hffffffff, rd);
    ahb(1'b0, 8'h10, 32'h0, rd);
    chk("unmapped", rd, 32'h0);
    repeat (6) wait_word();
    ahb(1'b0, DSW_OFF_WORD, 32'h0, rd);
    chk("strobe model word", {31'h0, is_rot(rd[7:0])}, 32'h1);
    ahb(1'b1, DSW_OFF_CTRL, 32'h7, rd);
    repeat (4) wait_word();
    ahb(1'b0, DSW_OFF_WORD, 32'h0, rd);
    w0 = rd[7:0];
    chk("link word", {31'h0, is_rot(w0)}, 32'h1);
    run_slips(1'b1, w0);
    // Slip off: request must do nothing
    ahb(1'b1, DSW_OFF_CTRL, 32'h5, rd);
    slip_pulse(w0, w0);
    ahb(1'b0, DSW_OFF_SLIPS, 32'h0, rd);
    chk("slips unchanged", rd & 32'hffff, 32'(slips));
    ce1 <= 1'b0;
    pattern <= 8'hff;
    repeat (4) wait_word();
    ahb(1'b0, DSW_OFF_WORD, 32'h0, rd);
    chk("frozen word", {31'h0, is_rot(rd[7:0])}, 32'h1);
    ce1 <= 1'b1;
    repeat (4) wait_word();
    ahb(1'b0, DSW_OFF_WORD, 32'h0, rd);
    chk("enabled word", rd, 32'hff);
    pattern <= 8'h93;
    wait_word();
    drst <= 1'b1;
    repeat (6) @(posedge hclk);
    chk("word in reset", {24'h0, pwo}, 32'h0);
    ahb(1'b0, DSW_OFF_STATUS, 32'h0, rd);
    chk("resets held", (rd >> DSW_STAT_WORD_RST) & 32'h3, 32'h3);
    wait_word();
    drst <= 1'b0;
    repeat (8) @(posedge hclk);
    ahb(1'b0, DSW_OFF_STATUS, 32'h0, rd);
    chk("before word edge", (rd >> DSW_STAT_WORD_RST) & 32'h3, 32'h3);
    wait_word();
    repeat (4) @(posedge hclk);
    ahb(1'b0, DSW_OFF_STATUS, 32'h0, rd);
    chk("word released", (rd >> DSW_STAT_WORD_RST) & 32'h3, 32'h2);
    repeat (12) @(posedge hclk);
    ahb(1'b0, DSW_OFF_STATUS, 32'h0, rd);
    chk("all released", (rd >> DSW_STAT_WORD_RST) & 32'h3, 32'h0);
    // Device reset also clears the slip counter
    slips = 0;
    ahb(1'b0, DSW_OFF_SLIPS, 32'h0, rd);
    chk("slips cleared", rd & 32'hffff, 32'h0);
    // Single rate: reframe under reset after the rate change
    ddr <= 1'b0;
    drst <= 1'b1;
    ahb(1'b1, DSW_OFF_CTRL, 32'h6, rd);
    repeat (4) wait_word();
    drst <= 1'b0;
    repeat (6) wait_word();
    ahb(1'b0, DSW_OFF_WORD, 32'h0, rd);
    w0 = rd[7:0];
    chk("sdr word", {31'h0, is_rot(w0)}, 32'h1);
    run_slips(1'b0, w0);
    // Second enable low: input word stage holds its last word
    ce2 <= 1'b0;
    pattern <= 8'hff;
    repeat (4) wait_word();
    ahb(1'b0, DSW_OFF_WORD, 32'h0, rd);
    chk("word stage held", rd, {24'h0, w0});
    ce2 <= 1'b1;
    repeat (4) wait_word();
    ahb(1'b0, DSW_OFF_WORD, 32'h0, rd);
    chk("word stage loads", rd, 32'hff);
    stop_test();
  end
endmodule : test_dsw_input_deserializer
